/* File: design/pps_pkg.sv */
package pps_pkg;

   localparam int unsigned IDX_W = 12;

   // register offsets are not word aligned: keep them as indices, byte address = 4 * index
   localparam logic [IDX_W-1:0] IDX_CTRL = 12'h096;
   localparam logic [IDX_W-1:0] IDX_STAT = 12'h098;
   localparam logic [IDX_W-1:0] IDX_RSVD = 12'h09A;
   localparam int unsigned      ADDR_W   = IDX_W + 2;

   localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_STAT = {IDX_STAT, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_RSVD = {IDX_RSVD, 2'h0};

   localparam int unsigned ADV_W = 5;

   typedef struct packed {
      logic             rsvd;
      logic             tx_off;
      logic             an_restart;
      logic             fef_off;
      logic             power_down;
      logic             auto_mdix_off;
      logic             force_mdix;
      logic             far_loop;
      logic             an_en;
      logic             force_100;
      logic             force_full;
      logic [ADV_W-1:0] adv;
   } pps_ctrl_t;

   localparam pps_ctrl_t CTRL_RST = 16'h00FF;

   typedef struct packed {
      logic             xover_alg;
      logic             rsvd;
      logic             pol_rev;
      logic             tx_fc;
      logic             rx_fc;
      logic             speed_100;
      logic             full_dup;
      logic             far_fault;
      logic             mdix;
      logic             an_done;
      logic             link_good;
      logic [ADV_W-1:0] partner;
   } pps_stat_t;

   localparam logic XOVER_ALG_RST = 1'h1;

   // raw indications from the port's PHY, not on this clock
   typedef struct packed {
      logic             fiber;
      logic             pol_rev;
      logic             tx_fc;
      logic             rx_fc;
      logic             speed_100;
      logic             full_dup;
      logic             far_fault;
      logic             mdix;
      logic             an_done;
      logic             link_good;
      logic [ADV_W-1:0] partner;
   } pps_phy_in_t;

   // effective settings steering the PHY
   typedef struct packed {
      logic             tx_off;
      logic             an_restart;
      logic             fef_detect;
      logic             power_down;
      logic             auto_mdix;
      logic             force_mdix;
      logic             far_loop;
      logic             an_en;
      logic             force_100;
      logic             force_full;
      logic             xover_std;
      logic [ADV_W-1:0] adv;
   } pps_phy_out_t;

   // management register select for the alias path
   localparam logic [1:0] MSEL_BCTRL = 2'h0;
   localparam logic [1:0] MSEL_ADV   = 2'h1;

   // bit positions in the basic control view
   localparam int unsigned MB_TXOFF = 1;
   localparam int unsigned MB_FEF   = 2;
   localparam int unsigned MB_AMDIX = 3;
   localparam int unsigned MB_FMDIX = 4;
   localparam int unsigned MB_XALG  = 5;
   localparam int unsigned MB_DUP   = 8;
   localparam int unsigned MB_RST   = 9;
   localparam int unsigned MB_PD    = 11;
   localparam int unsigned MB_ANEN  = 12;
   localparam int unsigned MB_SPD   = 13;
   localparam int unsigned MB_LOOP  = 14;
   // advertise view: pause at 10, abilities from 8 down to 5
   localparam int unsigned MA_PAUSE = 10;
   localparam int unsigned MA_ABIL  = 5;

endpackage : pps_pkg

/* File: design/pps_regs.sv */
`timescale 1ns/1ps
// Contract
// - transmit-disable bit 14 turns the port transmitter off while set.
// - writing one to bit 13 restarts auto-negotiation; the bit clears itself.
// - bit 12 disables far-end-fault detection, only meaningful in fiber mode.
// - bit 11 powers the PHY down, register contents unchanged.
// - bit 10 disables auto crossover; bit 9 forces MDI-X only when disabled.
// - bit 8 loops port 1 receive through port 2 PMD/PMA back out.
// - bit 7 (default one) enables auto-negotiation; else bits 6:5 decide.
// - with auto-negotiation off, bit 6 forces 100 (one) or 10 (zero).
// - bit 5 forces full/half when forced; failed auto-negotiation runs half.
// - bits 4:0 default one, advertise pause and four abilities; zero suppresses.
// - status bit 15 writable, default one, selects standard crossover algorithm.
// - status bit 13 reads one when receive polarity is reversed.
// - status bits 12 and 11 show transmit and receive flow control active.
// - status bit 10 shows speed 100; bit 9 shows full duplex.
// - status bit 8 set on far-end fault in fiber mode.
// - status bit 7 shows crossover state, one for MDI-X.
// - status bit 6 auto-negotiation done; bit 5 link good.
// - status bits 4:0 reflect link partner advertised abilities.
// - the word after the status register is reserved with no function.
module pps_regs
   import pps_pkg::*;
(
   input  wire logic                      i_clk,
   input  wire logic                      i_rst,
   input  wire logic [pps_pkg::ADDR_W-1:0] i_avs_address,
   input  wire logic                      i_avs_read,
   input  wire logic                      i_avs_write,
   input  wire logic [31:0]               i_avs_writedata,
   input  wire logic [3:0]                i_avs_byteenable,
   output logic      [31:0]               o_avs_readdata,
   output logic                           o_avs_waitrequest,
   input  wire logic                      i_mgmt_write,
   input  wire logic [1:0]                i_mgmt_sel,
   input  wire logic [15:0]               i_mgmt_wdata,
   output logic      [15:0]               o_mgmt_basic_control,
   output logic      [15:0]               o_mgmt_advertise,
   input  wire pps_pkg::pps_phy_in_t      i_phy,
   output pps_pkg::pps_phy_out_t          o_phy
);
   import pps_pkg::*;

   pps_ctrl_t   ctrl_r;
   pps_ctrl_t   ctrl_nxt;
   logic        xalg_r;
   logic        xalg_nxt;
   logic        ack_r;
   logic [31:0] rdata_r;
   pps_phy_in_t phy_meta_r;
   pps_phy_in_t phy_sync_r;
   pps_stat_t   stat;
   logic        bus_req;
   logic        bus_wr;
   logic        hit_ctrl;
   logic        hit_stat;
   logic        res_100;
   logic        res_full;

   // merge written bytes into a 16-bit register image
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      logic [15:0] v;
      v = old;
      if (be[0])
      begin
         v[7:0] = wd[7:0];
      end
      if (be[1])
      begin
         v[15:8] = wd[15:8];
      end
      return v;
   endfunction : merge16

   // management basic control view built from the shared storage
   function automatic logic [15:0] bctrl_view(input pps_ctrl_t c, input logic xa);
      logic [15:0] v;
      v           = 16'h0000;
      v[MB_TXOFF] = c.tx_off;
      v[MB_FEF]   = c.fef_off;
      v[MB_AMDIX] = c.auto_mdix_off;
      v[MB_FMDIX] = c.force_mdix;
      v[MB_XALG]  = xa;
      v[MB_DUP]   = c.force_full;
      v[MB_RST]   = c.an_restart;
      v[MB_PD]    = c.power_down;
      v[MB_ANEN]  = c.an_en;
      v[MB_SPD]   = c.force_100;
      v[MB_LOOP]  = c.far_loop;
      return v;
   endfunction : bctrl_view

   // pause plus the four abilities, pause on top
   function automatic logic [15:0] adv_view(input logic [ADV_W-1:0] a);
      logic [15:0] v;
      v                               = 16'h0000;
      v[MA_PAUSE]                     = a[ADV_W-1];
      v[MA_ABIL +: (ADV_W-1)]         = a[ADV_W-2:0];
      return v;
   endfunction : adv_view

   assign bus_req  = i_avs_read | i_avs_write;
   // a write lands only on the accept edge, never while waitrequest is high
   assign bus_wr   = i_avs_write & ack_r;
   assign hit_ctrl = (i_avs_address == ADDR_CTRL);
   assign hit_stat = (i_avs_address == ADDR_STAT);

   // one wait state: request is taken on the edge where ack_r is high
   assign o_avs_waitrequest = bus_req & ~ack_r;
   assign o_avs_readdata    = rdata_r;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ack_r <= 1'h0;
      end
      else
      begin
         ack_r <= bus_req & ~ack_r;
      end
   end

   // PHY indications are asynchronous: two flops before use
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         phy_meta_r <= '0;
         phy_sync_r <= '0;
      end
      else
      begin
         phy_meta_r <= i_phy;
         phy_sync_r <= phy_meta_r;
      end
   end

   // next value of the shared control storage; bus write on its accept edge
   always_comb
   begin
      ctrl_nxt            = ctrl_r;
      xalg_nxt            = xalg_r;
      ctrl_nxt.an_restart = 1'h0;
      if (i_mgmt_write && (i_mgmt_sel == MSEL_BCTRL))
      begin
         ctrl_nxt.tx_off        = i_mgmt_wdata[MB_TXOFF];
         ctrl_nxt.fef_off       = i_mgmt_wdata[MB_FEF];
         ctrl_nxt.auto_mdix_off = i_mgmt_wdata[MB_AMDIX];
         ctrl_nxt.force_mdix    = i_mgmt_wdata[MB_FMDIX];
         ctrl_nxt.force_full    = i_mgmt_wdata[MB_DUP];
         ctrl_nxt.an_restart    = i_mgmt_wdata[MB_RST];
         ctrl_nxt.power_down    = i_mgmt_wdata[MB_PD];
         ctrl_nxt.an_en         = i_mgmt_wdata[MB_ANEN];
         ctrl_nxt.force_100     = i_mgmt_wdata[MB_SPD];
         ctrl_nxt.far_loop      = i_mgmt_wdata[MB_LOOP];
         xalg_nxt               = i_mgmt_wdata[MB_XALG];
      end
      else if (i_mgmt_write && (i_mgmt_sel == MSEL_ADV))
      begin
         ctrl_nxt.adv = {i_mgmt_wdata[MA_PAUSE],
                         i_mgmt_wdata[MA_ABIL +: (ADV_W-1)]};
      end
      // bus write lands last so it wins a same-cycle collision
      if (bus_wr && hit_ctrl)
      begin
         ctrl_nxt      = pps_ctrl_t'(merge16(ctrl_r, i_avs_writedata, i_avs_byteenable));
         ctrl_nxt.rsvd = ctrl_r.rsvd;
         if (!i_avs_byteenable[1])
         begin
            ctrl_nxt.an_restart = 1'h0;
         end
      end
      if (bus_wr && hit_stat && i_avs_byteenable[1])
      begin
         xalg_nxt = i_avs_writedata[$bits(pps_stat_t)-1];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ctrl_r <= CTRL_RST;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         xalg_r <= XOVER_ALG_RST;
      end
      else
      begin
         xalg_r <= xalg_nxt;
      end
   end

   // both views read the one storage
   assign o_mgmt_basic_control = bctrl_view(ctrl_r, xalg_r);
   assign o_mgmt_advertise     = adv_view(ctrl_r.adv);

   // resolved mode: forced when auto-negotiation is off, half if it failed
   assign res_100  = ctrl_r.an_en ? phy_sync_r.speed_100 : ctrl_r.force_100;
   assign res_full = ctrl_r.an_en ? (phy_sync_r.an_done & phy_sync_r.full_dup)
                                  : ctrl_r.force_full;

   always_comb
   begin
      stat           = '0;
      stat.xover_alg = xalg_r;
      stat.pol_rev   = phy_sync_r.pol_rev;
      stat.tx_fc     = phy_sync_r.tx_fc;
      stat.rx_fc     = phy_sync_r.rx_fc;
      stat.speed_100 = res_100;
      stat.full_dup  = res_full;
      stat.far_fault = phy_sync_r.fiber & phy_sync_r.far_fault & ~ctrl_r.fef_off;
      stat.mdix      = phy_sync_r.mdix;
      stat.an_done   = phy_sync_r.an_done & ctrl_r.an_en;
      stat.link_good = phy_sync_r.link_good;
      stat.partner   = phy_sync_r.partner;
   end

   // read data registered on the edge that ends the wait state, one edge before the accept edge; reserved and unmapped read zero
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rdata_r <= 32'h00000000;
      end
      else if (i_avs_read && !ack_r)
      begin
         if (hit_ctrl)
         begin
            rdata_r <= {16'h0000, ctrl_r};
         end
         else if (hit_stat)
         begin
            rdata_r <= {16'h0000, stat};
         end
         else
         begin
            rdata_r <= 32'h00000000;
         end
      end
   end

   // drive the PHY
   always_comb
   begin
      o_phy            = '0;
      o_phy.tx_off     = ctrl_r.tx_off;
      o_phy.an_restart = ctrl_r.an_restart;
      // detection only exists on the fiber path
      o_phy.fef_detect = phy_sync_r.fiber & ~ctrl_r.fef_off;
      o_phy.power_down = ctrl_r.power_down;
      o_phy.auto_mdix  = ~ctrl_r.auto_mdix_off;
      o_phy.force_mdix = ctrl_r.auto_mdix_off & ctrl_r.force_mdix;
      o_phy.far_loop   = ctrl_r.far_loop;
      o_phy.an_en      = ctrl_r.an_en;
      o_phy.force_100  = ctrl_r.force_100;
      o_phy.force_full = ctrl_r.force_full;
      o_phy.xover_std  = xalg_r;
      o_phy.adv        = ctrl_r.adv;
   end

endmodule : pps_regs

/* File: test/pps_monitor.sv */
`timescale 1ns/1ps
module pps_monitor
   import pps_pkg::*;
(
   input wire logic                 i_clk,
   input wire logic                 i_rst,
   input wire logic                 i_avs_read,
   input wire logic                 i_avs_write,
   input wire logic                 o_avs_waitrequest,
   input wire logic                 i_mgmt_write,
   input wire logic [1:0]           i_mgmt_sel,
   input wire logic [15:0]          i_mgmt_wdata,
   input wire logic [15:0]          o_mgmt_basic_control,
   input wire logic [15:0]          o_mgmt_advertise,
   input wire pps_pkg::pps_phy_out_t o_phy
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence req_s; $rose(i_avs_read | i_avs_write); endsequence
   sequence one_wait_s; o_avs_waitrequest ##1 !o_avs_waitrequest; endsequence
   bus_wait_a: assert property (req_s |-> one_wait_s)
      else $error("bus wait state count wrong");
   restart_pulse_a: assert property (o_phy.an_restart |=> !o_phy.an_restart)
      else $error("restart pulse longer than one cycle");
   tx_alias_a: assert property (o_phy.tx_off == o_mgmt_basic_control[MB_TXOFF])
      else $error("transmitter off differs from alias");
   pd_alias_a: assert property (o_phy.power_down == o_mgmt_basic_control[MB_PD])
      else $error("power down differs from alias");
   mdix_force_a: assert property (o_phy.force_mdix == (o_mgmt_basic_control[MB_AMDIX]
      & o_mgmt_basic_control[MB_FMDIX]) && o_phy.auto_mdix != o_mgmt_basic_control[MB_AMDIX])
      else $error("crossover control wrong");
   adv_alias_a: assert property (o_phy.adv == {o_mgmt_advertise[MA_PAUSE],
      o_mgmt_advertise[8:5]}) else $error("advertise differs from alias");
   fef_gate_a: assert property (o_phy.fef_detect |-> !o_mgmt_basic_control[MB_FEF])
      else $error("fault detect on while disabled");
   mgmt_write_a: assert property (i_mgmt_write && i_mgmt_sel == MSEL_BCTRL && !i_avs_write
      |=> o_mgmt_basic_control[MB_LOOP] == $past(i_mgmt_wdata[MB_LOOP]))
      else $error("alias write lost");
   force_sel_a: assert property (o_phy.an_en == o_mgmt_basic_control[MB_ANEN]
      && o_phy.force_100 == o_mgmt_basic_control[MB_SPD]
      && o_phy.force_full == o_mgmt_basic_control[MB_DUP]) else $error("forced mode wrong");
endmodule : pps_monitor

/* File: test/pps_phy_model.sv */
`timescale 1ns/1ps
// behavioural port PHY: environment bits shaped by the control outputs
module pps_phy_model
   import pps_pkg::*;
(
   input wire logic [14:0]           i_env,
   input wire pps_pkg::pps_phy_out_t i_ctl,
   output pps_pkg::pps_phy_in_t      o_phy
);
   always_comb
   begin
      o_phy = pps_phy_in_t'(i_env);
      o_phy.link_good = i_env[5] & ~i_ctl.power_down;
      o_phy.far_fault = i_env[8] & i_ctl.fef_detect;
      o_phy.mdix = i_ctl.auto_mdix ? i_env[7] : i_ctl.force_mdix;
      if (!i_ctl.an_en)
      begin
         o_phy.speed_100 = i_ctl.force_100;
         o_phy.full_dup  = i_ctl.force_full;
      end
   end
endmodule : pps_phy_model

/* File: test/testbench.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
   import pps_pkg::*;
   logic              i_clk = 0, i_rst = 1, rd = 0, wr = 0, mw = 0, wreq;
   logic [ADDR_W-1:0] adr = '0;
   logic [31:0]       wd = '0, rdata, q;
   logic [3:0]        ben = 4'hF;
   logic [1:0]        msel = '0;
   logic [15:0]       mwd = '0, bc, adv, c, x, lf = 16'h0054;
   logic [14:0]       env = '0;
   pps_phy_in_t       phy;
   pps_phy_out_t      ctl;
   int                err_total = 0, n_tests = 0;
   initial forever #20 i_clk = ~i_clk;
   pps_regs dut_u (.i_clk, .i_rst, .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .i_avs_byteenable(ben), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wreq), .i_mgmt_write(mw), .i_mgmt_sel(msel), .i_mgmt_wdata(mwd),
      .o_mgmt_basic_control(bc), .o_mgmt_advertise(adv), .i_phy(phy), .o_phy(ctl));
   pps_phy_model phy_u (.i_env(env), .i_ctl(ctl), .o_phy(phy));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] d,
                      input logic [3:0] b = 4'hF);
      @(posedge i_clk);
      wr <= w; rd <= !w; adr <= a; wd <= {16'h0000, d}; ben <= b;
      // waitrequest and read data are both taken at the accepting rising edge
      do
      begin
         @(posedge i_clk);
      end while (wreq !== 1'b0);
      q = rdata;
      wr <= 1'b0; rd <= 1'b0;
   endtask : bus
   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [15:0] e);
      bus(1'b0, a, 16'h0000);
      `CHK("read", {16'h0000, e}, q)
   endtask : rdchk
   task automatic mgmt(input logic [1:0] s, input logic [15:0] d);
      @(posedge i_clk);
      mw <= 1'b1; msel <= s; mwd <= d;
      @(posedge i_clk);
      mw <= 1'b0;
   endtask : mgmt
   // expected views and status from the bench copy of control and crossover bit
   task automatic verify(input string nm);
      logic [15:0]  s;
      logic [15:0]  v;
      pps_phy_out_t e;
      repeat (4) @(posedge i_clk);
      rdchk(ADDR_CTRL, c);
      v = {1'b0, c[8], c[6], c[7], c[11], 2'h0, c[5], 2'h0,
           x[0], c[9], c[10], c[12], c[14], 1'b0};
      `CHK("bctl", v, bc)
      `CHK("adv", {5'h00, c[4], 1'b0, c[3:0], 5'h00}, adv)
      e = {c[14], 1'b0, phy.fiber & ~c[12], c[11], ~c[10], c[10] & c[9], c[8],
           c[7], c[6], c[5], x[0], c[4:0]};
      `CHK("phy", e, ctl)
      s = {x[0], 1'b0, phy[13:11], c[7] ? phy.speed_100 : c[6],
         c[7] ? phy.full_dup & phy.an_done : c[5], phy.fiber & phy.far_fault & ~c[12],
         phy.mdix, phy.an_done & c[7], phy.link_good, phy.partner};
      rdchk(ADDR_STAT, s);
      $display("test %s done", nm);
   endtask : verify
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : summarize
   initial
   begin
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      c = 16'h00FF;
      x = 16'h0001;
      verify("reset");
      for (int i = 0; i < 12; i++)
      begin
         lf = lfsr(lf);
         env <= lf[14:0];
         lf = lfsr(lf);
         bus(1'b1, ADDR_CTRL, lf);
         c = lf & 16'h5FFF;
         verify("random");
      end
      bus(1'b1, ADDR_CTRL, 16'h2000);
      @(negedge i_clk);
      `CHK("restart", 1'b1, ctl.an_restart)
      @(negedge i_clk);
      `CHK("restart end", 1'b0, ctl.an_restart)
      c = 16'h0000;
      verify("restart");
      bus(1'b1, ADDR_STAT, 16'h7FFF);
      x = 16'h0000;
      verify("status write");
      // upper lane disabled: crossover bit and restart must not move
      bus(1'b1, ADDR_STAT, 16'h8000, 4'h1);
      bus(1'b1, ADDR_CTRL, 16'h20FF, 4'h1);
      c = 16'h00FF;
      verify("byte lanes");
      bus(1'b1, ADDR_RSVD, 16'hFFFF);
      rdchk(ADDR_RSVD, 16'h0000);
      verify("reserved");
      mgmt(MSEL_BCTRL, 16'h7122);
      c = 16'h41E0 | (c & 16'h001F);
      x = 16'h0001;
      mgmt(MSEL_ADV, 16'h0400);
      c = (c & 16'hFFE0) | 16'h0010;
      verify("alias");
      summarize();
   end
   initial
   begin
      repeat (5000) @(posedge i_clk);
      err_total++;
      summarize();
   end
endmodule : testbench
bind pps_regs pps_monitor mon_u (.i_clk, .i_rst, .i_avs_read, .i_avs_write, .o_avs_waitrequest,
   .i_mgmt_write, .i_mgmt_sel, .i_mgmt_wdata, .o_mgmt_basic_control, .o_mgmt_advertise, .o_phy);
